//--- design/gst_cmp_if.sv
`timescale 1ns/1ps
interface gst_cmp_if;
  logic save;
  logic clear;
  logic view_live;
  logic [5:0] sample;
  logic [5:0] live;
  logic [15:0] word;
  modport owner (
    output save,
    output clear,
    output view_live,
    output sample,
    output live,
    input word
  );
  modport store (
    input save,
    input clear,
    input view_live,
    input sample,
    input live,
    output word
  );
endinterface

//--- design/gst_compare_store.sv
`timescale 1ns/1ps
module gst_compare_store (
  input wire logic clk_i,
  input wire logic reset_n_i,
  gst_cmp_if.store cmp
);
  logic [5:0] saved_q;
  logic [5:0] saved_d;
  logic [15:0] word;

  ////////////////////////////////////////////////////////////////////////////
  // Saved samples; a save in the clear cycle wins so no sample is lost
  // clear saved samples
  always_comb
  begin
    saved_d = saved_q;
    if (cmp.clear)
    begin
      saved_d = gst_pkg::SAMPLE_RESET;
    end
    if (cmp.save)
    begin
      saved_d = cmp.sample;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      saved_q <= gst_pkg::SAMPLE_RESET;
    end
    else
    begin
      saved_q <= saved_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word layout; odd bits and upper bits stay zero
  // unused bits zero
  always_comb
  begin
    word = 16'h0000;
    for (int i = 0; i < gst_pkg::POSITIONS; i++)
    begin
      word[gst_pkg::COMPARE_TOP_BIT - gst_pkg::COMPARE_BIT_STEP * i] =
        cmp.view_live ? cmp.live[i] : saved_q[i];
    end
  end

  assign cmp.word = word;
endmodule

//--- design/gst_pkg.sv
package gst_pkg;
  // Register addresses (write side and read side)
  localparam logic [7:0] SCRATCH_WR_ADDR = 8'h7c;
  localparam logic [7:0] SCRATCH_RD_ADDR = 8'hfc;
  localparam logic [7:0] STATUS_RD_ADDR = 8'he4;
  localparam logic [7:0] COMPARE_RD_ADDR = 8'he8;
  // Status word fields
  localparam int RUNNING_BIT = 5;
  localparam int MISMATCH_BIT = 4;
  localparam int STEP_LSB = 0;
  localparam int STEP_WIDTH = 3;
  // Control word fields, decoded outside this block
  localparam int VIEW_SELECT_BIT = 4;
  localparam int RESULT_CLEAR_BIT = 7;
  localparam int TEST_PERMIT_BIT = 12;
  // Compare word: position i sits at bit TOP - STEP * i
  localparam int POSITIONS = 6;
  localparam int COMPARE_TOP_BIT = 10;
  localparam int COMPARE_BIT_STEP = 2;
  // Reset values
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [5:0] SAMPLE_RESET = 6'h00;
  localparam logic [2:0] STEP_RESET = 3'h0;
  // Test type code without expected-value check
  localparam logic [1:0] TYPE_D = 2'h3;
endpackage

//--- design/gst_status_regs.sv
`timescale 1ns/1ps
// Operation
// - Status bit 5 reads 1 while the self-test runs, else 0.
// - Status bit 4 latches any expected-value mismatch during a run.
// - Mismatch indicator is meaningful only for types A, B and C.
// - Status bits 2:0 show the last executed step number.
// - After a mismatch the step field holds the failing step.
// - View select low: compare bits return last saved samples.
// - View select high: compare bits return live filtered outputs.
// - High sides of U, V, W sit at bits 10, 6, 2.
// - Low sides at bits 8, 4, 0; other bits read zero.
// - Sixteen-bit scratch register, reset zero, no side effect.
// - Control bit 4 chooses saved samples (0) or live outputs (1).
// - Control bit 7 clears saved samples and mismatch; self-clearing.
// - Clearing test permit bit 12 cancels a run; running reads 0.
module gst_status_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [15:0] control_word_i,
  input wire logic [15:0] control2_word_i,
  input wire logic [1:0] test_type_i,
  input wire logic seq_running_i,
  input wire logic step_done_i,
  input wire logic [2:0] step_index_i,
  input wire logic mismatch_i,
  input wire logic sample_save_i,
  input wire logic [5:0] sample_i,
  input wire logic [5:0] live_compare_i
);
  logic [15:0] scratch_q;
  logic [15:0] scratch_d;
  logic running_q;
  logic running_d;
  logic mismatch_q;
  logic mismatch_d;
  logic [2:0] last_step_index_q;
  logic [2:0] last_step_index_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic saved_result_clear;
  logic compare_view_select;
  logic test_permit;
  logic mismatch_event;
  logic [15:0] status_word;

  gst_cmp_if cmp ();

  ////////////////////////////////////////////////////////////////////////////
  // Control decode; the clear bit is a write pulse, never stored here
  // clear pulse
  assign saved_result_clear = control_word_i[gst_pkg::RESULT_CLEAR_BIT];
  assign compare_view_select = control_word_i[gst_pkg::VIEW_SELECT_BIT];
  assign test_permit = control2_word_i[gst_pkg::TEST_PERMIT_BIT];
  assign mismatch_event = mismatch_i & seq_running_i & test_permit &
    (test_type_i != gst_pkg::TYPE_D);

  assign cmp.save = sample_save_i;
  assign cmp.clear = saved_result_clear;
  assign cmp.view_live = compare_view_select;
  assign cmp.sample = sample_i;
  assign cmp.live = live_compare_i;

  gst_compare_store u_store (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cmp(cmp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Self-test status
  always_comb
  begin
    running_d = seq_running_i & test_permit;
    mismatch_d = mismatch_q;
    last_step_index_d = last_step_index_q;
    if (saved_result_clear)
    begin
      mismatch_d = 1'b0;
    end
    if (mismatch_event)
    begin
      mismatch_d = 1'b1;
    end
    if (step_done_i && !(mismatch_q && !saved_result_clear))
    begin
      last_step_index_d = step_index_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      running_q <= 1'b0;
      mismatch_q <= 1'b0;
      last_step_index_q <= gst_pkg::STEP_RESET;
    end
    else
    begin
      running_q <= running_d;
      mismatch_q <= mismatch_d;
      last_step_index_q <= last_step_index_d;
    end
  end

  always_comb
  begin
    status_word = gst_pkg::STATUS_RESET;
    status_word[gst_pkg::RUNNING_BIT] = running_q;
    status_word[gst_pkg::MISMATCH_BIT] = mismatch_q;
    status_word[gst_pkg::STEP_LSB +: gst_pkg::STEP_WIDTH] = last_step_index_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port; reads only load the answer flop
  always_comb
  begin
    scratch_d = scratch_q;
    if (reg_wr_i && reg_addr_i == gst_pkg::SCRATCH_WR_ADDR)
    begin
      scratch_d = reg_wdata_i;
    end
    rvalid_d = reg_rd_i;
    rdata_d = rdata_q;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        gst_pkg::SCRATCH_RD_ADDR: rdata_d = scratch_q;
        gst_pkg::STATUS_RD_ADDR: rdata_d = status_word;
        gst_pkg::COMPARE_RD_ADDR: rdata_d = cmp.word;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      scratch_q <= gst_pkg::SCRATCH_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      scratch_q <= scratch_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
endmodule

//--- test/gst_checker.sv
`timescale 1ns/1ps
module gst_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [15:0] control_word_i,
  input wire logic [15:0] control2_word_i,
  input wire logic seq_running_i,
  input wire logic mismatch_i,
  input wire logic [5:0] live_compare_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  function automatic logic [15:0] pl(input logic [5:0] s);
    pl = 16'h0000;
    for (int i = 0; i < 6; i++)
      pl[10-2*i] = s[i];
  endfunction
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_wr;
    reg_wr_i && reg_addr_i == 8'h7c;
  endsequence
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("no answer");
  scratch_back_a: assert property (s_wr ##1 !reg_wr_i ##1 s_rd(8'hfc)
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("scratch");
  unmapped_zero_a: assert property (reg_rd_i &&
    !(reg_addr_i inside {8'hfc, 8'he4, 8'he8}) |=> reg_rdata_o == 16'h0)
    else $error("unmapped");
  compare_zero_a: assert property (s_rd(8'he8)
    |=> (reg_rdata_o & 16'hfaaa) == 16'h0) else $error("odd bits");
  live_view_a: assert property (s_rd(8'he8) ##0 control_word_i[4]
    |=> reg_rdata_o == pl($past(live_compare_i))) else $error("live");
  // Previous and current cycle both required since running lags one cycle
  running_flag_a: assert property (s_rd(8'he4) ##0
    $past(seq_running_i && control2_word_i[12] && reset_n_i) &&
    seq_running_i && control2_word_i[12] |=> reg_rdata_o[5])
    else $error("running");
  cancel_run_a: assert property (s_rd(8'he4) ##0 !control2_word_i[12] &&
    !$past(control2_word_i[12]) |=> !reg_rdata_o[5]) else $error("cancel");
  clear_flag_a: assert property (control_word_i[7] && !mismatch_i
    ##1 !mismatch_i ##1 s_rd(8'he4) |=> !reg_rdata_o[4]) else $error("clear");
endmodule
bind gst_status_regs gst_checker gst_checker_i (.clk_i, .reset_n_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .control_word_i, .control2_word_i, .seq_running_i,
  .mismatch_i, .live_compare_i);

//--- test/gst_host_model.sv
`timescale 1ns/1ps
module gst_host_model (
  input wire logic clk_i,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [15:0] wdata_o = 16'h0000,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i
);
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Missing answer turns into unknown data
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    // Answer taken at the edge where rvalid is sampled high
    @(posedge clk_i);
    d = rvalid_i ? rdata_i : 16'hxxxx;
  endtask
endmodule

//--- test/gst_status_regs_tb_top.sv
`timescale 1ns/1ps
module gst_status_regs_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr, rd, rv, run, done, mis, save;
  logic [7:0] ad;
  logic [15:0] wd, rdat, cw, cw2, got, r;
  logic [1:0] typ;
  logic [2:0] idx;
  logic [5:0] smp, live, v;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  gst_status_regs gst_status_regs_i (.clk_i, .reset_n_i, .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .control_word_i(cw), .control2_word_i(cw2),
    .test_type_i(typ), .seq_running_i(run), .step_done_i(done),
    .step_index_i(idx), .mismatch_i(mis), .sample_save_i(save),
    .sample_i(smp), .live_compare_i(live));
  gst_host_model gst_host_model_i (.clk_i, .wr_o(wr), .rd_o(rd),
    .addr_o(ad), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  function automatic logic [15:0] pl(input logic [5:0] s);
    pl = 16'h0000;
    for (int i = 0; i < 6; i++)
      pl[10-2*i] = s[i];
  endfunction
  task close_out;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task rchk(input logic [7:0] a, input logic [15:0] e);
    gst_host_model_i.rd(a, got);
    compares++;
    if (got !== e)
    begin
      err_count++;
      $display("BAD %0t read %h got %h want %h", $time, a, got, e);
    end
  endtask
  task step(input logic [2:0] i, input logic m);
    @(posedge clk_i);
    done <= 1'b1;
    idx <= i;
    mis <= m;
    @(posedge clk_i);
    done <= 1'b0;
    mis <= 1'b0;
  endtask
  task pulse_clear;
    @(posedge clk_i);
    cw <= cw | 16'h0080;
    @(posedge clk_i);
    cw <= cw & 16'hff7f;
  endtask
  initial
  begin
    #20000;
    err_count++;
    close_out;
  end
  initial
  begin
    {cw, cw2, typ, run, done, mis, save, idx, smp, live} = '0;
    void'($urandom(82));
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    gst_host_model_i.wr(8'he4, 16'hffff);
    rchk(8'he4, 16'h0000);
    rchk(8'he8, 16'h0000);
    rchk(8'hfc, 16'h0000);
    repeat (6)
    begin
      r = 16'($urandom);
      gst_host_model_i.wr(8'h7c, r);
      rchk(8'hfc, r);
      rchk(8'h7c, 16'h0000);
    end
    cw2 <= 16'h1000;
    run <= 1'b1;
    step(3'h2, 1'b1);
    rchk(8'he4, 16'h0032);
    step(3'h5, 1'b0);
    rchk(8'he4, 16'h0032);
    pulse_clear();
    rchk(8'he4, 16'h0022);
    step(3'h7, 1'b0);
    rchk(8'he4, 16'h0027);
    typ <= 2'h3;
    step(3'h6, 1'b1);
    rchk(8'he4, 16'h0026);
    cw2 <= 16'h0000;
    rchk(8'he4, 16'h0006);
    rchk(8'he4, 16'h0006);
    for (int k = 0; k < 6; k++)
    begin
      v = (k == 0) ? 6'h3f : 6'($urandom);
      @(posedge clk_i);
      save <= 1'b1;
      smp <= v;
      cw <= 16'h0000;
      @(posedge clk_i);
      save <= 1'b0;
      rchk(8'he8, pl(v));
      v = 6'($urandom);
      live <= v;
      cw <= 16'h0010;
      rchk(8'he8, pl(v));
    end
    live <= 6'h01;
    rchk(8'he8, 16'h0400);
    live <= 6'h02;
    rchk(8'he8, 16'h0100);
    cw <= 16'h0000;
    rchk(8'he8, pl(smp));
    // Save and clear in one cycle: the save wins
    @(posedge clk_i);
    save <= 1'b1;
    smp <= 6'h3f;
    cw <= 16'h0080;
    @(posedge clk_i);
    save <= 1'b0;
    cw <= 16'h0000;
    rchk(8'he8, 16'h0555);
    pulse_clear();
    rchk(8'he8, 16'h0000);
    close_out;
  end
endmodule
